// File: inc/sram_ctl_pkg.sv
// Shared widths, reset values, pin bundles and write decoding for the
// synchronous burst SRAM control logic.
// Assumes one system clock; SRAM pins arrive unsynchronised.
`default_nettype none
package sram_ctl_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Widths and counts
   localparam int ADDR_W = 16;
   localparam int HI_W = 14;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int WORDS = 65536;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and other constants
   localparam logic [1:0] STEP_RST = 2'h0;
   localparam logic [1:0] BASE_RST = 2'h0;
   localparam logic [HI_W-1:0] HI_RST = 14'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam logic [LANES-1:0] ALL_LANES = 4'hF;
   localparam logic [LANES-1:0] NO_LANES = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // Cycle kinds decoded at each SRAM clock edge
   typedef enum logic [3:0]
   {
      OP_NONE = 4'h1,
      OP_DESEL = 4'h2,
      OP_READ = 4'h4,
      OP_WRITE = 4'h8
   } op_t;

   // Synchronous control pins, all sampled on the SRAM clock
   typedef struct packed
   {
      logic chip_select_low_n;
      logic chip_select_high;
      logic chip_select_low2_n;
      logic proc_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_step_n;
      logic all_bytes_write_n;
      logic byte_write_gate_n;
      logic [LANES-1:0] lane_write_n;
   } ctrl_t;

   // Everything that crosses into the system clock
   typedef struct packed
   {
      logic ck;
      ctrl_t ctrl;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
      logic burst_order_select;
      logic output_path_select;
      logic sleep_request;
   } pins_t;

   localparam pins_t PINS_RST = '0;

   // Lanes written this cycle; all zero means a read
   function automatic logic [LANES-1:0] wr_lanes(input ctrl_t c);
      if (!c.all_bytes_write_n)
         return ALL_LANES;
      else if (!c.byte_write_gate_n)
         return ~c.lane_write_n;
      else
         return NO_LANES;
   endfunction
endpackage
`default_nettype wire

// File: logic/burst_step_counter.sv
// Two-bit burst address counter, linear or interleaved order.
// Assumes load and advance are already qualified by the SRAM clock edge.
`timescale 1ns/10ps
`default_nettype none
module burst_step_counter
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic advance,
   input wire logic linear,
   input wire logic [1:0] ext_lo,
   // Address used this edge
   output logic [1:0] addr_lo
);
   import sram_ctl_pkg::*;

   logic [1:0] base_r;
   logic [1:0] step_r;
   logic [1:0] base_sel;
   logic [1:0] step_sel;

   ////////////////////////////////////////////////////////////////////////
   // Address seen this edge, so a load or step takes effect at once
   always_comb
   begin
      base_sel = load ? ext_lo : base_r;
      step_sel = load ? STEP_RST : (advance ? step_r + STEP_ONE : step_r);
      if (linear)
         addr_lo = base_sel + step_sel;
      else
         addr_lo = base_sel ^ step_sel;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         base_r <= BASE_RST;
      else if (load)
         base_r <= ext_lo;
   end

   // Step wraps modulo four, so the fifth edge returns to the start
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         step_r <= STEP_RST;
      else
         step_r <= step_sel;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_step_advance: assert property
      (advance && !load |=> step_r == $past(step_r) + STEP_ONE)
      else $error("burst step did not advance by one");
   a_load_preset: assert property
      (load |-> addr_lo == ext_lo)
      else $error("loaded address not used at once");
   a_interleave_map: assert property
      (!linear && advance && !load |-> addr_lo == (base_r ^ (step_r + 2'h1)))
      else $error("interleaved address wrong");
endmodule
`default_nettype wire

// File: logic/sram_word_array.sv
// 64K by 32 storage with per-lane write and registered read.
// Assumes strobes are one system clock long.
`timescale 1ns/10ps
`default_nettype none
module sram_word_array
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Access
   input wire logic we,
   input wire logic re,
   input wire logic [sram_ctl_pkg::LANES-1:0] lane_we,
   input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr,
   input wire logic [sram_ctl_pkg::DATA_W-1:0] wdata,
   // Read data, valid the cycle after re
   output logic [sram_ctl_pkg::DATA_W-1:0] rdata_r
);
   import sram_ctl_pkg::*;

   // Contents are never reset, so sleep keeps them; one array row per lane
   // so that each lane process owns its own part of the storage
   logic [LANE_W-1:0] mem [0:LANES-1][0:WORDS-1];

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : lane
         always_ff @(posedge clk)
         begin
            if (we && lane_we[g])
               mem[g][addr] <= wdata[g*LANE_W +: LANE_W];
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_r <= DATA_RST;
      else if (re)
      begin
         for (int i = 0; i < LANES; i++)
            rdata_r[i*LANE_W +: LANE_W] <= mem[i][addr];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_read_back: assert property
      (we && lane_we[0] |=> mem[0][$past(addr)] == $past(wdata[LANE_W-1:0]))
      else $error("byte written was not stored");
endmodule
`default_nettype wire

// File: logic/sync_burst_sram_control.sv
// Control of a 64K x 32 synchronous burst SRAM, clocked on clk.
// Assumes the SRAM clock pin is slow enough for clk to find its edges.
// How it works
// - Burst order pin low counts linearly; high counts interleaved.
// - Path pin low gives flow-through output; high gives pipelined output.
// - Sleep pin high stops all cycles and floats outputs.
// - Linear bursts add the step to the loaded low bits, modulo four.
// - Interleaved bursts XOR the loaded low bits with the step count.
// - Byte gate low writes each lane whose enable is low.
// - No write decoded means a read driving all four lanes.
// - Data pins stay floated during every write cycle.
// - Deselect combinations use no address and float the data pins.
// - Selected with processor strobe, or controller strobe without write, reads.
// - Selected with controller strobe only and a write decoded, writes.
// - Burst step low with strobes idle advances to the next address.
// - Burst step high with strobes idle repeats the current address.
// - Output enable high floats drivers at once; low only enables reads.
// - Global write low writes all four lanes, ignoring lane enables.
// - Pipeline mode adds one SRAM clock of read latency.
// - A deselect turns outputs off one stage before read data would.
// - Memory keeps its contents through sleep or a stopped clock.
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_control
(
   // System clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // SRAM clock pin
   input wire logic sram_ck,
   // Synchronous pins
   input wire sram_ctl_pkg::ctrl_t ctrl_pins,
   input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_pins,
   // Data pins
   input wire logic [sram_ctl_pkg::DATA_W-1:0] dq_in,
   output logic [sram_ctl_pkg::DATA_W-1:0] dq_out,
   output logic [sram_ctl_pkg::LANES-1:0] dq_oe,
   // Asynchronous and static pins
   input wire logic output_enable_n,
   input wire logic burst_order_select,
   input wire logic output_path_select,
   input wire logic sleep_request
);
   import sram_ctl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   pins_t raw;
   pins_t s1_r;
   pins_t s2_r;
   logic ck_prev_r;
   logic ck_rise;
   ctrl_t c;

   assign raw = {sram_ck, ctrl_pins, addr_pins, dq_in, burst_order_select,
                 output_path_select, sleep_request};

   // Clock and data share the same two stages, so they stay aligned
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s1_r <= PINS_RST;
      else
         s1_r <= raw;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s2_r <= PINS_RST;
      else
         s2_r <= s1_r;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ck_prev_r <= 1'b0;
      else
         ck_prev_r <= s2_r.ck;
   end

   assign ck_rise = s2_r.ck && !ck_prev_r;
   assign c = s2_r.ctrl;

   ////////////////////////////////////////////////////////////////////////
   // Cycle decode
   logic sel_true;
   logic [LANES-1:0] lanes;
   logic wr;
   logic flow;
   logic idle_strobes;
   op_t op_nxt;
   logic load;
   logic advance;

   assign sel_true = c.chip_select_high && !c.chip_select_low2_n;
   assign lanes = wr_lanes(c);
   assign wr = |lanes;
   assign flow = !s2_r.output_path_select;
   assign idle_strobes = c.ctrl_addr_strobe_n &&
                         (c.proc_addr_strobe_n || c.chip_select_low_n);

   always_comb
   begin
      op_nxt = OP_NONE;
      load = 1'b0;
      advance = 1'b0;
      if (s2_r.sleep_request)
         op_nxt = OP_NONE;
      else if ((c.chip_select_low_n && !c.ctrl_addr_strobe_n) ||
               (!c.chip_select_low_n && !sel_true &&
                (!c.proc_addr_strobe_n || !c.ctrl_addr_strobe_n)))
         op_nxt = OP_DESEL;
      else if (!c.chip_select_low_n && sel_true &&
               (!c.proc_addr_strobe_n ||
                (!c.ctrl_addr_strobe_n && !wr)))
      begin
         op_nxt = OP_READ;
         load = 1'b1;
      end
      else if (!c.chip_select_low_n && sel_true &&
               !c.ctrl_addr_strobe_n && wr)
      begin
         op_nxt = OP_WRITE;
         load = 1'b1;
      end
      else if (idle_strobes)
      begin
         op_nxt = wr ? OP_WRITE : OP_READ;
         advance = !c.burst_step_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address path
   logic [HI_W-1:0] hi_r;
   logic [1:0] addr_lo;
   logic [ADDR_W-1:0] mem_addr;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         hi_r <= HI_RST;
      else if (ck_rise && load)
         hi_r <= s2_r.addr[ADDR_W-1:2];
   end

   burst_step_counter u_counter
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(ck_rise && load),
      .advance(ck_rise && advance),
      .linear(!s2_r.burst_order_select),
      .ext_lo(s2_r.addr[1:0]),
      .addr_lo(addr_lo)
   );

   assign mem_addr = {(load ? s2_r.addr[ADDR_W-1:2] : hi_r), addr_lo};

   ////////////////////////////////////////////////////////////////////////
   // Storage
   logic mem_we;
   logic mem_re;
   logic [DATA_W-1:0] rdata;

   assign mem_we = ck_rise && op_nxt == OP_WRITE;
   assign mem_re = ck_rise && op_nxt == OP_READ;

   sram_word_array u_array
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .we(mem_we),
      .re(mem_re),
      .lane_we(lanes),
      .addr(mem_addr),
      .wdata(s2_r.din),
      .rdata_r(rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output path
   logic rd_done_r;
   logic pipe_full_r;
   logic [DATA_W-1:0] held_r;
   logic [DATA_W-1:0] dq_out_r;
   logic drive_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rd_done_r <= 1'b0;
      else
         rd_done_r <= mem_re;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         held_r <= DATA_RST;
      else if (rd_done_r)
         held_r <= rdata;
   end

   // A read waits in this stage until the next SRAM clock edge
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pipe_full_r <= 1'b0;
      else if (ck_rise)
         pipe_full_r <= op_nxt == OP_READ;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         dq_out_r <= DATA_RST;
      else if (flow && rd_done_r)
         dq_out_r <= rdata;
      else if (!flow && ck_rise && pipe_full_r)
         dq_out_r <= held_r;
   end

   // Deselect and write switch drivers off at the capturing edge itself,
   // one stage ahead of the read pipeline
   always_ff @(posedge clk)
   begin
      if (sys_rst || s2_r.sleep_request)
         drive_r <= 1'b0;
      else if (ck_rise && op_nxt != OP_READ)
         drive_r <= 1'b0;
      else if (ck_rise && !flow)
         drive_r <= pipe_full_r;
      else if (flow && rd_done_r)
         drive_r <= 1'b1;
   end

   // Output enable gates the pins directly, without the synchroniser
   assign dq_oe = {LANES{drive_r && !output_enable_n}};
   assign dq_out = dq_out_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_flow_read;
      ck_rise && op_nxt == OP_READ && flow;
   endsequence

   sequence s_flow_shown;
      ##2 (drive_r && dq_out_r == $past(rdata));
   endsequence

   a_flow_read_out: assert property
      (s_flow_read ##1 !s2_r.sleep_request && flow |-> s_flow_shown)
      else $error("flow-through read not shown two cycles later");
   a_pipe_first_quiet: assert property
      (ck_rise && op_nxt == OP_READ && !flow && !pipe_full_r |=> !drive_r)
      else $error("pipelined read drove too early");
   a_write_floats: assert property
      (ck_rise && op_nxt == OP_WRITE |=> !drive_r ##1 !drive_r)
      else $error("data driven during a write");
   a_desel_floats: assert property
      (ck_rise && op_nxt == OP_DESEL |=> !drive_r && !mem_we && !mem_re)
      else $error("deselect left drivers on");
   a_oe_gate: assert property
      (output_enable_n |-> dq_oe == NO_LANES)
      else $error("drivers on while output enable high");
   a_global_write: assert property
      (mem_we && !c.all_bytes_write_n |-> lanes == ALL_LANES)
      else $error("global write missed a lane");
   a_lane_write: assert property
      (mem_we && c.all_bytes_write_n && !c.byte_write_gate_n
       |-> lanes == ~c.lane_write_n)
      else $error("lane write pattern wrong");
   a_proc_read: assert property
      (!s2_r.sleep_request && !c.chip_select_low_n && sel_true &&
       !c.proc_addr_strobe_n |-> op_nxt == OP_READ && load)
      else $error("processor strobe did not start a read");
   a_sleep_idle: assert property
      (s2_r.sleep_request |-> op_nxt == OP_NONE ##1 !drive_r)
      else $error("cycle decoded while asleep");
   a_hi_hold: assert property
      (ck_rise && advance |-> mem_addr[ADDR_W-1:2] == hi_r)
      else $error("upper address moved inside a burst");
   // Pipelined word leaves the holding stage at the next read edge
   a_pipe_deliver: assert property
      (ck_rise && op_nxt == OP_READ && !flow && pipe_full_r
       |=> drive_r && dq_out_r == $past(held_r))
      else $error("pipelined read data not shown");
   a_oe_follows: assert property
      (!output_enable_n && drive_r |-> dq_oe == ALL_LANES)
      else $error("drivers off although a read is active");
   a_upper_load: assert property
      (ck_rise && load |=> hi_r == $past(s2_r.addr[ADDR_W-1:2]))
      else $error("upper address not loaded");
endmodule
`default_nettype wire

// File: tb/sram_bus_master.sv
// Processor-side model that drives the SRAM clock, controls and data.
// Assumes one task call per SRAM clock; the clock idles low between calls.
`timescale 1ns/10ps
`default_nettype none
module sram_bus_master
(
   // SRAM pins
   output logic sram_ck,
   output sram_ctl_pkg::ctrl_t ctrl_pins,
   output logic [sram_ctl_pkg::ADDR_W-1:0] addr_pins,
   output logic [sram_ctl_pkg::DATA_W-1:0] dq_in,
   input wire logic [sram_ctl_pkg::DATA_W-1:0] dq_out,
   input wire logic [sram_ctl_pkg::LANES-1:0] dq_oe,
   // Seen at the end of each cycle
   output logic [sram_ctl_pkg::DATA_W-1:0] q_seen,
   output logic [sram_ctl_pkg::LANES-1:0] oe_seen
);
   import sram_ctl_pkg::*;
   initial
   begin
      sram_ck = 1'h0;
      ctrl_pins = 12'hD7F;
      addr_pins = 16'h0000;
      dq_in = 32'h00000000;
   end
   ////////////////////////////////////////////////////////////////////////
   // One 125 ns SRAM clock; pins held from before rise until the fall
   task automatic cycle(input ctrl_t c, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic wr);
      // Pins may change on a system clock edge, so no race with its flops
      ctrl_pins <= c;
      addr_pins <= a;
      // Released data bus shows the complement of the word it last held
      dq_in <= wr ? d : ~dq_in;
      #62.5 sram_ck <= 1'h1;
      // Sampled half a nanosecond before the fall, never on a clk edge
      #62 q_seen = dq_out;
      oe_seen = dq_oe;
      #0.5 sram_ck <= 1'h0;
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the synchronous burst SRAM control block.
// Assumes sram_bus_master drives every synchronous SRAM pin.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sram_ctl_pkg::*;
   // Control words: cs_low_n, cs_high, cs_low2_n, strobes, step, writes
   localparam ctrl_t C_WR = 12'h55F;
   localparam ctrl_t C_RDP = 12'h4FF;
   localparam ctrl_t C_RDC = 12'h57F;
   localparam ctrl_t C_BWR = 12'h560;
   localparam ctrl_t C_CWR = 12'h59F;
   localparam ctrl_t C_CRD = 12'hDBF;
   localparam ctrl_t C_SWR = 12'h5DF;
   localparam ctrl_t C_DS1 = 12'hD7F;
   localparam ctrl_t C_DS2 = 12'h15F;
   logic clk;
   logic sys_rst;
   logic oe_n;
   logic order_sel;
   logic path_sel;
   logic sleep;
   logic sram_ck;
   ctrl_t ctrl_pins;
   logic [ADDR_W-1:0] addr_pins;
   logic [DATA_W-1:0] dq_in;
   logic [DATA_W-1:0] dq_out;
   logic [LANES-1:0] dq_oe;
   logic [DATA_W-1:0] q_seen;
   logic [LANES-1:0] oe_seen;
   int failures;
   int checked;

   sync_burst_sram_control dut_u
   (
      .clk(clk), .sys_rst(sys_rst), .sram_ck(sram_ck),
      .ctrl_pins(ctrl_pins), .addr_pins(addr_pins),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .output_enable_n(oe_n), .burst_order_select(order_sel),
      .output_path_select(path_sel), .sleep_request(sleep)
   );
   sram_bus_master bus_u
   (
      .sram_ck(sram_ck), .ctrl_pins(ctrl_pins), .addr_pins(addr_pins),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .q_seen(q_seen), .oe_seen(oe_seen)
   );

   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr1(input logic [15:0] a, input logic [31:0] d);
      bus_u.cycle(C_WR, a, d, 1'h1);
      chk("write oe", 32'h0, {28'h0, oe_seen});
   endtask

   // Flow-through read; data lands within the same SRAM clock
   task automatic rdf(input logic [15:0] a, input logic [31:0] e);
      bus_u.cycle(C_RDP, a, 32'h0, 1'h0);
      chk("read data", e, q_seen);
      chk("read oe", 32'hF, {28'h0, oe_seen});
   endtask

   task automatic s_single;
      wr1(16'h1234, 32'hA5A5_5A5A);
      bus_u.cycle(C_RDC, 16'h1234, 32'h0, 1'h0);
      chk("ctrl read", 32'hA5A5_5A5A, q_seen);
      bus_u.cycle(C_BWR | 12'h00F, 16'h1234, 32'h0, 1'h0);
      chk("gate read", 32'hA5A5_5A5A, q_seen);
      chk("gate oe", 32'hF, {28'h0, oe_seen});
   endtask

   task automatic s_lanes;
      for (int i = 0; i < 4; i++)
      begin
         wr1(16'h0777, 32'h0);
         bus_u.cycle(C_BWR | ~(12'h1 << i) & 12'h00F, 16'h0777,
            32'hFFFF_FFFF, 1'h1);
         chk("lane oe", 32'h0, {28'h0, oe_seen});
         rdf(16'h0777, 32'hFF << (8 * i));
      end
   endtask

   task automatic s_burst(input logic lin);
      logic [15:0] a;
      logic [1:0] s;
      a = lin ? 16'h3C41 : 16'h3C42;
      s = a[1:0];
      @(negedge clk) order_sel = ~lin;
      wr1(a, 32'hB000_0000);
      // Wrong upper bits on the pins must be ignored
      for (int k = 1; k < 5; k++)
         bus_u.cycle(C_CWR, ~a, 32'hB000_0000 + k, 1'h1);
      rdf(a, 32'hB000_0004);
      for (int k = 1; k < 4; k++)
         rdf({a[15:2], lin ? s + k[1:0] : s ^ k[1:0]},
            32'hB000_0000 + k);
      rdf(a, 32'hB000_0004);
      for (int k = 1; k < 4; k++)
      begin
         bus_u.cycle(C_CRD, ~a, 32'h0, 1'h0);
         chk("burst read", 32'hB000_0000 + k, q_seen);
      end
   endtask

   task automatic s_suspend;
      wr1(16'h0501, 32'h2222_2222);
      wr1(16'h0500, 32'h1111_1111);
      bus_u.cycle(C_SWR, 16'hFAFF, 32'h3333_3333, 1'h1);
      rdf(16'h0500, 32'h3333_3333);
      rdf(16'h0501, 32'h2222_2222);
   endtask

   task automatic s_desel;
      bus_u.cycle(C_DS2, 16'h1234, 32'hDEAD_BEEF, 1'h1);
      rdf(16'h1234, 32'hA5A5_5A5A);
      bus_u.cycle(C_DS1, 16'h1234, 32'h0, 1'h0);
      chk("deselect oe", 32'h0, {28'h0, oe_seen});
   endtask

   task automatic s_oe;
      rdf(16'h1234, 32'hA5A5_5A5A);
      @(negedge clk) oe_n = 1'h1;
      #1 chk("oe off", 32'h0, {28'h0, dq_oe});
      @(negedge clk) oe_n = 1'h0;
      #1 chk("oe back", 32'hF, {28'h0, dq_oe});
   endtask

   // A deselect empties the pipe first, so the mode change carries no word
   task automatic s_pipe;
      @(negedge clk) path_sel = 1'h1;
      bus_u.cycle(C_DS1, 16'h0, 32'h0, 1'h0);
      chk("pipe empty oe", 32'h0, {28'h0, oe_seen});
      bus_u.cycle(C_RDP, 16'h0500, 32'h0, 1'h0);
      chk("pipe first oe", 32'h0, {28'h0, oe_seen});
      bus_u.cycle(C_RDP, 16'h1234, 32'h0, 1'h0);
      chk("pipe data", 32'h3333_3333, q_seen);
      chk("pipe oe", 32'hF, {28'h0, oe_seen});
      bus_u.cycle(C_DS1, 16'h0, 32'h0, 1'h0);
      chk("single deselect", 32'h0, {28'h0, oe_seen});
      @(negedge clk) path_sel = 1'h0;
   endtask

   task automatic s_sleep;
      rdf(16'h1234, 32'hA5A5_5A5A);
      @(negedge clk) sleep = 1'h1;
      repeat (4) @(negedge clk);
      chk("sleep oe", 32'h0, {28'h0, dq_oe});
      bus_u.cycle(C_WR, 16'h1234, 32'hDEAD_BEEF, 1'h1);
      @(negedge clk) sleep = 1'h0;
      repeat (4) @(negedge clk);
      rdf(16'h1234, 32'hA5A5_5A5A);
   endtask

   task automatic stop_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Bounded run; a hang counts as a mismatch
   initial
   begin
      #100000;
      failures++;
      stop_test();
   end

   initial
   begin
      failures = 0;
      checked = 0;
      sys_rst = 1'h1;
      oe_n = 1'h0;
      order_sel = 1'h0;
      path_sel = 1'h0;
      sleep = 1'h0;
      repeat (8) @(posedge clk);
      @(negedge clk) sys_rst = 1'h0;
      repeat (4) @(negedge clk);
      s_single();
      s_lanes();
      s_burst(1'h1);
      s_burst(1'h0);
      s_suspend();
      s_desel();
      s_oe();
      s_pipe();
      s_sleep();
      stop_test();
   end
endmodule
`default_nettype wire
